//--- headroom_gain_pkg.sv
// constants, register map and decode functions for the headroom gain compressor
package headroom_gain_pkg;

  // register offsets
  localparam logic [7:0] ADDR_VOLUME = 8'h2D;
  localparam logic [7:0] ADDR_GAIN_SCALE = 8'h2E;
  localparam logic [7:0] ADDR_MIN_ROTATION = 8'h31;

  // values after reset
  localparam logic [7:0] VOLUME_RESET = 8'h00;
  localparam logic [7:0] GAIN_SCALE_RESET = 8'h00;
  localparam logic [7:0] MIN_ROTATION_RESET = 8'h00;

  // field positions
  localparam int RAMP_BYPASS_BIT = 7;
  localparam int UPPER_NIBBLE_LSB = 4;
  localparam logic [6:0] MUTE_CODE = 7'h7F;

  // 0.5 dB units; 12 units make one 6 dB halving
  localparam logic [7:0] HALF_DB_PER_OCTAVE = 8'h0C;
  localparam logic [7:0] GAIN_HEADROOM_HALF_DB = 8'h0C;
  localparam logic [5:0] LEVEL_FLOOR = 6'h3F;

  // supply ADC: 5.35 V plus 50 mV per code, in 10 mV units
  localparam logic [11:0] SUPPLY_BASE_CV = 12'h217;
  localparam logic [11:0] SUPPLY_STEP_CV = 12'h005;

  // converter full scale 2.1 dBV and analog gain base 9.5 dB, in 0.1 dB units
  localparam logic [7:0] DAC_FULL_SCALE_TENTH_DBV = 8'h15;
  localparam logic [7:0] FS_GAIN_BASE_TENTH_DB = 8'h5F;
  localparam logic [7:0] FS_GAIN_STEP_TENTH_DB = 8'h0A;
  localparam logic [3:0] LAST_GAIN_CODE = 4'hB;

  // timing
  localparam int CLOCK_MHZ = 250;
  localparam int ATTACK_STEP_NS = 17500;
  localparam int ATTACK_STEP_CYCLES = (ATTACK_STEP_NS * CLOCK_MHZ + 999) / 1000;
  localparam int RELEASE_UNIT_MS = 1;
  localparam int RELEASE_UNIT_CYCLES = RELEASE_UNIT_MS * CLOCK_MHZ * 1000;
  localparam int VOLUME_STEP_NS = 10000;
  localparam int VOLUME_STEP_CYCLES = (VOLUME_STEP_NS * CLOCK_MHZ + 999) / 1000;

  typedef enum logic [3:0] {
    MODE_PASS = 4'b0001,
    MODE_COMPRESS = 4'b0010,
    MODE_HARD_LIMIT = 4'b0100,
    MODE_RATIO_HOLD = 4'b1000
  } comp_mode_t;

  // linear factor of an attenuation of n half-dB, Q15 (8000 is unity)
  function automatic logic [15:0] half_db_to_q15(input logic [7:0] n);
    logic [15:0] m;
    logic [7:0] q;
    logic [3:0] r;
    q = n / HALF_DB_PER_OCTAVE;
    r = 4'(n % HALF_DB_PER_OCTAVE);
    unique case (r)
      4'h0: m = 16'h8000;
      4'h1: m = 16'h78D7;
      4'h2: m = 16'h7215;
      4'h3: m = 16'h6BB3;
      4'h4: m = 16'h65AD;
      4'h5: m = 16'h5FFD;
      4'h6: m = 16'h5A9E;
      4'h7: m = 16'h558C;
      4'h8: m = 16'h50C3;
      4'h9: m = 16'h4C3F;
      4'hA: m = 16'h47FB;
      4'hB: m = 16'h43F4;
      default: m = 16'h0000;
    endcase
    return m >> q;
  endfunction

  // peak output voltage of 0 dBFS, 10 mV units; reserved codes act as the top setting
  function automatic logic [10:0] peak_voltage_cv(input logic [3:0] code, input logic min_table);
    logic [10:0] v;
    unique case (code)
      4'h0: v = 11'h219;
      4'h1: v = 11'h25B;
      4'h2: v = 11'h2A5;
      4'h3: v = 11'h2F7;
      4'h4: v = 11'h354;
      4'h5: v = 11'h3BC;
      4'h6: v = 11'h430;
      4'h7: v = 11'h4B3;
      4'h8: v = 11'h546;
      4'h9: v = 11'h5EB;
      4'hA: v = 11'h6A3;
      default: v = min_table ? 11'h708 : 11'h773;
    endcase
    return v;
  endfunction

endpackage

//--- sample_gain_stage.sv
// one-cycle multiply of a sample by a half-dB attenuation with saturation
`timescale 1ns/10ps
`default_nettype none
module sample_gain_stage #(
  parameter int W = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic signed [W-1:0] sample_i,
  input wire logic valid_i,
  input wire logic [7:0] net_atten_i,
  input wire logic mute_i,
  output logic signed [W-1:0] sample_o,
  output logic valid_o
);
  localparam logic signed [W+16:0] POS_LIMIT = (W+17)'({1'b0, {(W-1){1'b1}}});
  localparam logic signed [W+16:0] NEG_LIMIT = -POS_LIMIT - (W+17)'(1);

  logic [15:0] factor;
  logic signed [W+16:0] product;
  logic signed [W+16:0] scaled;
  logic signed [W-1:0] next_sample;

  assign factor = headroom_gain_pkg::half_db_to_q15(net_atten_i);
  assign product = (W+17)'(sample_i) * $signed({1'b0, factor});
  // unity sits 12 half-dB down the table, so shift by 14 instead of 15 for 6 dB of boost room
  assign scaled = product >>> 14;

  always_comb begin
    if (mute_i) begin
      next_sample = '0;
    end else if (scaled > POS_LIMIT) begin
      next_sample = W'(POS_LIMIT);
    end else if (scaled < NEG_LIMIT) begin
      next_sample = W'(NEG_LIMIT);
    end else begin
      next_sample = W'(scaled);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_o <= '0;
      valid_o <= 1'b0;
    end else begin
      valid_o <= valid_i;
      if (valid_i) begin
        sample_o <= next_sample;
      end
    end
  end
endmodule // sample_gain_stage
`default_nettype wire

//--- headroom_gain_compressor.sv
// volume, digital gain, output scaling and supply-tracking compressor datapath
`timescale 1ns/10ps
`default_nettype none
module headroom_gain_compressor #(
  parameter int SAMPLE_W = 24,
  parameter int ATTACK_STEP_CYCLES = headroom_gain_pkg::ATTACK_STEP_CYCLES,
  parameter int RELEASE_UNIT_CYCLES = headroom_gain_pkg::RELEASE_UNIT_CYCLES
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WRITE_I,
  input wire logic REG_READ_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RDATA_VALID_O,
  input wire logic signed [SAMPLE_W-1:0] SAMPLE_I,
  input wire logic SAMPLE_VALID_I,
  input wire logic [7:0] SUPPLY_RAW_I,
  input wire logic [7:0] SUPPLY_FILT_I,
  input wire logic SUPPLY_FILTER_SELECT_I,
  input wire logic [2:0] ATTACK_RATE_I,
  input wire logic [2:0] RELEASE_RATE_I,
  input wire logic SHUTDOWN_I,
  output logic signed [SAMPLE_W-1:0] SAMPLE_O,
  output logic SAMPLE_VALID_O,
  output logic [7:0] ANALOG_GAIN_O,
  output logic [7:0] OUTPUT_LEVEL_OFFSET_O,
  output logic [3:0] COMPRESSOR_MODE_O,
  output logic [5:0] COMPRESSOR_ATTEN_O,
  output logic VOLUME_SETTLED_O
);
  // rotation level in half-dB below full scale
  function automatic logic [5:0] rotation_half_db(input logic [3:0] code);
    logic [5:0] r;
    unique case (code)
      4'h0: r = 6'h01;
      4'h1: r = 6'h02;
      4'h2: r = 6'h04;
      4'h3: r = 6'h06;
      4'h4: r = 6'h08;
      4'h5: r = 6'h08;
      4'h6: r = 6'h0C;
      4'h7: r = 6'h0C;
      4'h8: r = 6'h14;
      4'h9: r = 6'h18;
      4'hA: r = 6'h1E;
      default: r = 6'h24;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] pre_gain_half_db(input logic [3:0] code);
    logic [7:0] g;
    unique case (code)
      4'h9: g = 8'h0A;
      4'hA: g = 8'h0C;
      default: g = (code <= 4'h8) ? {4'h0, code} : 8'h00;
    endcase
    return g;
  endfunction

  function automatic logic [12:0] release_ms(input logic [2:0] code);
    logic [12:0] t;
    unique case (code)
      3'h0: t = 13'h002D;
      3'h1: t = 13'h00E1;
      3'h2: t = 13'h01C2;
      3'h3: t = 13'h047E;
      3'h4: t = 13'h08CA;
      3'h5: t = 13'h0C1C;
      3'h6: t = 13'h1194;
      default: t = 13'h1A5E;
    endcase
    return t;
  endfunction

  logic [7:0] volume_attenuation;
  logic [7:0] gain_and_output_scaling;
  logic [7:0] min_gain_and_rotation;

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      volume_attenuation <= headroom_gain_pkg::VOLUME_RESET;
      gain_and_output_scaling <= headroom_gain_pkg::GAIN_SCALE_RESET;
      min_gain_and_rotation <= headroom_gain_pkg::MIN_ROTATION_RESET;
    end else if (REG_WRITE_I) begin
      // reserved codes are stored as written and only clamped where they are decoded, except pre-gain codes B-F, which decode to 0 half-dB
      unique case (REG_ADDR_I)
        headroom_gain_pkg::ADDR_VOLUME: volume_attenuation <= REG_WDATA_I;
        headroom_gain_pkg::ADDR_GAIN_SCALE: gain_and_output_scaling <= REG_WDATA_I;
        headroom_gain_pkg::ADDR_MIN_ROTATION: min_gain_and_rotation <= REG_WDATA_I;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      REG_RDATA_O <= 8'h00;
      REG_RDATA_VALID_O <= 1'b0;
    end else begin
      REG_RDATA_VALID_O <= REG_READ_I;
      if (REG_READ_I) begin
        unique case (REG_ADDR_I)
          headroom_gain_pkg::ADDR_VOLUME: REG_RDATA_O <= volume_attenuation;
          headroom_gain_pkg::ADDR_GAIN_SCALE: REG_RDATA_O <= gain_and_output_scaling;
          headroom_gain_pkg::ADDR_MIN_ROTATION: REG_RDATA_O <= min_gain_and_rotation;
          default: REG_RDATA_O <= 8'h00;
        endcase
      end
    end
  end

  logic [6:0] volume_attenuation_code;
  logic volume_ramp_bypass;
  logic [3:0] pre_conversion_gain;
  logic [3:0] full_scale_output_gain;
  logic [3:0] minimum_gain_voltage;
  logic [3:0] rotation_level_select;
  logic [3:0] fs_code_valid;

  assign volume_attenuation_code = volume_attenuation[6:0];
  assign volume_ramp_bypass = volume_attenuation[headroom_gain_pkg::RAMP_BYPASS_BIT];
  assign pre_conversion_gain = gain_and_output_scaling[headroom_gain_pkg::UPPER_NIBBLE_LSB +: 4];
  assign full_scale_output_gain = gain_and_output_scaling[3:0];
  assign minimum_gain_voltage = min_gain_and_rotation[headroom_gain_pkg::UPPER_NIBBLE_LSB +: 4];
  assign rotation_level_select = min_gain_and_rotation[3:0];
  assign fs_code_valid = (full_scale_output_gain > headroom_gain_pkg::LAST_GAIN_CODE) ?
                         headroom_gain_pkg::LAST_GAIN_CODE : full_scale_output_gain;

  logic [7:0] next_analog_gain;
  assign next_analog_gain = 8'(headroom_gain_pkg::FS_GAIN_BASE_TENTH_DB +
                               8'(fs_code_valid) * headroom_gain_pkg::FS_GAIN_STEP_TENTH_DB);

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      ANALOG_GAIN_O <= headroom_gain_pkg::FS_GAIN_BASE_TENTH_DB;
      OUTPUT_LEVEL_OFFSET_O <= 8'(headroom_gain_pkg::FS_GAIN_BASE_TENTH_DB +
                                  headroom_gain_pkg::DAC_FULL_SCALE_TENTH_DBV);
    end else begin
      ANALOG_GAIN_O <= next_analog_gain;
      OUTPUT_LEVEL_OFFSET_O <= 8'(next_analog_gain + headroom_gain_pkg::DAC_FULL_SCALE_TENTH_DBV);
    end
  end

  // supply and level measurement: a 64-step scan compares each quantity against
  // thresholds 0.5 dB apart, trading a slow refresh for no logarithm hardware
  logic [7:0] supply_code;
  logic [11:0] supply_cv;
  logic [10:0] peak_cv;
  logic [10:0] min_cv;
  logic [5:0] scan_idx;
  logic [15:0] scan_factor;
  logic [11:0] peak_ref;
  logic [SAMPLE_W-1:0] input_ref;
  logic [SAMPLE_W-1:0] sample_mag;
  logic [SAMPLE_W-1:0] window_peak;
  logic supply_hit;
  logic min_hit;
  logic input_hit;
  logic supply_found;
  logic min_found;
  logic input_found;
  logic [5:0] supply_acc;
  logic [5:0] min_acc;
  logic [5:0] input_acc;
  logic [5:0] supply_level;
  logic [5:0] min_level;
  logic [5:0] input_level;

  assign supply_code = SUPPLY_FILTER_SELECT_I ? SUPPLY_FILT_I : SUPPLY_RAW_I;
  assign supply_cv = 12'(headroom_gain_pkg::SUPPLY_BASE_CV +
                         12'(supply_code) * headroom_gain_pkg::SUPPLY_STEP_CV);
  assign peak_cv = headroom_gain_pkg::peak_voltage_cv(fs_code_valid, 1'b0);
  assign min_cv = headroom_gain_pkg::peak_voltage_cv(minimum_gain_voltage, 1'b1);
  assign scan_factor = headroom_gain_pkg::half_db_to_q15({2'b00, scan_idx});
  assign peak_ref = 12'((27'(peak_cv) * 27'(scan_factor)) >> 15);
  assign input_ref = SAMPLE_W'({{(SAMPLE_W-16){1'b0}}, scan_factor} << (SAMPLE_W-16));
  assign sample_mag = SAMPLE_I[SAMPLE_W-1] ? SAMPLE_W'(~SAMPLE_I + 1'b1) : SAMPLE_W'(SAMPLE_I);
  assign supply_hit = supply_cv >= peak_ref;
  assign min_hit = 12'(min_cv) >= peak_ref;
  assign input_hit = window_peak >= input_ref;

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      scan_idx <= 6'h00;
      supply_found <= 1'b0;
      min_found <= 1'b0;
      input_found <= 1'b0;
      supply_acc <= headroom_gain_pkg::LEVEL_FLOOR;
      min_acc <= headroom_gain_pkg::LEVEL_FLOOR;
      input_acc <= headroom_gain_pkg::LEVEL_FLOOR;
      supply_level <= 6'h00;
      min_level <= headroom_gain_pkg::LEVEL_FLOOR;
      input_level <= headroom_gain_pkg::LEVEL_FLOOR;
      window_peak <= '0;
    end else begin
      scan_idx <= scan_idx + 6'h01;
      if (!supply_found && supply_hit) begin
        supply_found <= 1'b1;
        supply_acc <= scan_idx;
      end
      if (!min_found && min_hit) begin
        min_found <= 1'b1;
        min_acc <= scan_idx;
      end
      if (!input_found && input_hit) begin
        input_found <= 1'b1;
        input_acc <= scan_idx;
      end
      if (SAMPLE_VALID_I && sample_mag > window_peak) begin
        window_peak <= sample_mag;
      end
      if (scan_idx == headroom_gain_pkg::LEVEL_FLOOR) begin
        supply_level <= supply_found ? supply_acc : headroom_gain_pkg::LEVEL_FLOOR;
        min_level <= min_found ? min_acc : headroom_gain_pkg::LEVEL_FLOOR;
        input_level <= input_found ? input_acc : headroom_gain_pkg::LEVEL_FLOOR;
        supply_found <= 1'b0;
        min_found <= 1'b0;
        input_found <= 1'b0;
        window_peak <= SAMPLE_VALID_I ? sample_mag : '0;
      end
    end
  end

  // mode selection and target attenuation
  headroom_gain_pkg::comp_mode_t mode;
  headroom_gain_pkg::comp_mode_t next_mode;
  logic [5:0] rotation_level;
  logic [5:0] ratio_supply;
  logic [11:0] ratio_product;
  logic [5:0] next_target;
  logic [5:0] target;

  assign rotation_level = rotation_half_db(rotation_level_select);

  always_comb begin
    if (supply_level == 6'h00) begin
      next_mode = headroom_gain_pkg::MODE_PASS;
    end else if (supply_level > min_level) begin
      next_mode = headroom_gain_pkg::MODE_RATIO_HOLD;
    end else if (supply_level > rotation_level) begin
      next_mode = headroom_gain_pkg::MODE_HARD_LIMIT;
    end else begin
      next_mode = headroom_gain_pkg::MODE_COMPRESS;
    end
  end

  // in ratio hold the supply depth is pinned at the minimum-gain depth, so output clips
  assign ratio_supply = (mode == headroom_gain_pkg::MODE_RATIO_HOLD) ? min_level : supply_level;
  assign ratio_product = 12'(ratio_supply) * 12'(rotation_level - input_level);

  always_comb begin
    next_target = 6'h00;
    unique case (mode)
      headroom_gain_pkg::MODE_PASS: next_target = 6'h00;
      headroom_gain_pkg::MODE_COMPRESS,
      headroom_gain_pkg::MODE_RATIO_HOLD: begin
        if (input_level < rotation_level) begin
          next_target = 6'(ratio_product / 12'(rotation_level));
        end
      end
      headroom_gain_pkg::MODE_HARD_LIMIT: begin
        if (input_level < supply_level) begin
          next_target = supply_level - input_level;
        end
      end
      default: next_target = 6'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      mode <= headroom_gain_pkg::MODE_PASS;
      target <= 6'h00;
    end else begin
      mode <= next_mode;
      target <= next_target;
    end
  end

  // ballistics: one half-dB step per period; the step time never looks at
  // the output, so clipping does not change how long an attack takes
  logic [5:0] comp_atten;
  logic [31:0] ballistic_timer;
  logic [31:0] attack_period;
  logic [31:0] release_period;

  assign attack_period = 32'(ATTACK_STEP_CYCLES) << ATTACK_RATE_I;
  assign release_period = 32'(RELEASE_UNIT_CYCLES) * 32'(release_ms(RELEASE_RATE_I));

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      comp_atten <= 6'h00;
      ballistic_timer <= 32'h0000_0000;
    end else if (comp_atten < target) begin
      if (ballistic_timer >= attack_period - 32'h1) begin
        comp_atten <= comp_atten + 6'h01;
        ballistic_timer <= 32'h0000_0000;
      end else begin
        ballistic_timer <= ballistic_timer + 32'h1;
      end
    end else if (comp_atten > target) begin
      if (ballistic_timer >= release_period - 32'h1) begin
        comp_atten <= comp_atten - 6'h01;
        ballistic_timer <= 32'h0000_0000;
      end else begin
        ballistic_timer <= ballistic_timer + 32'h1;
      end
    end else begin
      ballistic_timer <= 32'h0000_0000;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      COMPRESSOR_MODE_O <= headroom_gain_pkg::MODE_PASS;
      COMPRESSOR_ATTEN_O <= 6'h00;
    end else begin
      COMPRESSOR_MODE_O <= mode;
      COMPRESSOR_ATTEN_O <= comp_atten;
    end
  end

  // volume ramp: starts from mute after reset and returns to mute on shutdown
  logic [6:0] applied_volume;
  logic [6:0] volume_goal;
  logic [11:0] volume_timer;
  logic volume_mute;

  assign volume_goal = SHUTDOWN_I ? headroom_gain_pkg::MUTE_CODE : volume_attenuation_code;

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      applied_volume <= headroom_gain_pkg::MUTE_CODE;
      volume_timer <= 12'h000;
    end else if (volume_ramp_bypass) begin
      applied_volume <= volume_goal;
      volume_timer <= 12'h000;
    end else if (applied_volume == volume_goal) begin
      volume_timer <= 12'h000;
    end else if (volume_timer == 12'(headroom_gain_pkg::VOLUME_STEP_CYCLES - 1)) begin
      volume_timer <= 12'h000;
      if (applied_volume < volume_goal) begin
        applied_volume <= applied_volume + 7'h01;
      end else begin
        applied_volume <= applied_volume - 7'h01;
      end
    end else begin
      volume_timer <= volume_timer + 12'h001;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      VOLUME_SETTLED_O <= 1'b0;
    end else begin
      VOLUME_SETTLED_O <= (applied_volume == volume_goal);
    end
  end

  assign volume_mute = (applied_volume == headroom_gain_pkg::MUTE_CODE);

  // all three stages fold into one multiply: volume and compressor add depth, gain removes it
  logic [7:0] net_atten;
  assign net_atten = 8'({1'b0, applied_volume} + {2'b00, comp_atten} +
                        headroom_gain_pkg::GAIN_HEADROOM_HALF_DB -
                        pre_gain_half_db(pre_conversion_gain));

  sample_gain_stage #(
    .W(SAMPLE_W)
  ) u_gain (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .sample_i(SAMPLE_I),
    .valid_i(SAMPLE_VALID_I),
    .net_atten_i(net_atten),
    .mute_i(volume_mute),
    .sample_o(SAMPLE_O),
    .valid_o(SAMPLE_VALID_O)
  );
endmodule // headroom_gain_compressor
`default_nettype wire

//--- headroom_gain_compressor_properties.sv
// port-level checks for the headroom gain compressor
`timescale 1ns/10ps
`default_nettype none
module headroom_gain_compressor_properties #(
  parameter int SAMPLE_W = 24,
  parameter int ATTACK_STEP_CYCLES = headroom_gain_pkg::ATTACK_STEP_CYCLES
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WRITE_I,
  input wire logic REG_READ_I,
  input wire logic REG_RDATA_VALID_O,
  input wire logic SAMPLE_VALID_I,
  input wire logic signed [SAMPLE_W-1:0] SAMPLE_O,
  input wire logic SAMPLE_VALID_O,
  input wire logic [7:0] ANALOG_GAIN_O,
  input wire logic [7:0] OUTPUT_LEVEL_OFFSET_O,
  input wire logic [3:0] COMPRESSOR_MODE_O,
  input wire logic [5:0] COMPRESSOR_ATTEN_O,
  input wire logic VOLUME_SETTLED_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  logic [7:0] exp_gain;
  logic [5:0] prev_atten;
  logic [15:0] since_inc;
  logic gain_wr;
  assign gain_wr = REG_WRITE_I && REG_ADDR_I == headroom_gain_pkg::ADDR_GAIN_SCALE;
  // reserved codes act as the top setting
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I)
      exp_gain <= 8'h5F;
    else if (gain_wr)
      exp_gain <= (REG_WDATA_I[3:0] > 4'hB) ? 8'hCD : 8'h5F + 8'(REG_WDATA_I[3:0]) * 8'h0A;
  end
  // saturating gap counter so the first step after reset never looks early
  always_ff @(posedge CORE_CLK_I) begin
    prev_atten <= COMPRESSOR_ATTEN_O;
    if (RST_I)
      since_inc <= 16'hFFFF;
    else if (COMPRESSOR_ATTEN_O > prev_atten)
      since_inc <= 16'h0001;
    else if (since_inc != 16'hFFFF)
      since_inc <= since_inc + 16'h0001;
  end
  sequence s_settle;
    ##[1:4] VOLUME_SETTLED_O;
  endsequence
  sequence s_gain_quiet;
    $stable(ANALOG_GAIN_O) [*2];
  endsequence
  a_read_answer: assert property (REG_READ_I |=> REG_RDATA_VALID_O) else $error("read not answered");
  a_sample_latency: assert property (SAMPLE_VALID_I |=> SAMPLE_VALID_O) else $error("sample lost");
  a_sample_hold: assert property (!SAMPLE_VALID_O |-> $stable(SAMPLE_O)) else $error("sample moved");
  a_offset_sum: assert property (s_gain_quiet |-> OUTPUT_LEVEL_OFFSET_O == ANALOG_GAIN_O + 8'h15)
    else $error("offset wrong");
  a_gain_decode: assert property (gain_wr |-> ##[1:3] ANALOG_GAIN_O == exp_gain)
    else $error("gain decode wrong");
  a_mode_onehot: assert property ($onehot(COMPRESSOR_MODE_O)) else $error("mode not one-hot");
  a_atten_step: assert property (COMPRESSOR_ATTEN_O != prev_atten |-> COMPRESSOR_ATTEN_O == prev_atten + 6'h01
    || COMPRESSOR_ATTEN_O == prev_atten - 6'h01) else $error("atten jumped");
  a_attack_gap: assert property (COMPRESSOR_ATTEN_O > prev_atten |-> since_inc >= 16'(ATTACK_STEP_CYCLES))
    else $error("attack too fast");
  a_bypass_settle: assert property (REG_WRITE_I && REG_ADDR_I == 8'h2D && REG_WDATA_I[7] |-> s_settle)
    else $error("bypass did not settle");
endmodule // headroom_gain_compressor_properties
bind headroom_gain_compressor headroom_gain_compressor_properties #(.SAMPLE_W(SAMPLE_W),
  .ATTACK_STEP_CYCLES(ATTACK_STEP_CYCLES)) props_inst (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WRITE_I(REG_WRITE_I), .REG_READ_I(REG_READ_I),
  .REG_RDATA_VALID_O(REG_RDATA_VALID_O), .SAMPLE_VALID_I(SAMPLE_VALID_I), .SAMPLE_O(SAMPLE_O),
  .SAMPLE_VALID_O(SAMPLE_VALID_O), .ANALOG_GAIN_O(ANALOG_GAIN_O), .OUTPUT_LEVEL_OFFSET_O(OUTPUT_LEVEL_OFFSET_O),
  .COMPRESSOR_MODE_O(COMPRESSOR_MODE_O), .COMPRESSOR_ATTEN_O(COMPRESSOR_ATTEN_O), .VOLUME_SETTLED_O(VOLUME_SETTLED_O));
`default_nettype wire

//--- audio_supply_source.sv
// far-side model: audio sample source and supply measurement readings
`timescale 1ns/10ps
`default_nettype none
module audio_supply_source (
  input wire logic clk_i,
  input wire logic tone_i,
  input wire logic [23:0] amp_i,
  input wire logic push_i,
  input wire logic [23:0] value_i,
  input wire logic [7:0] raw_code_i,
  input wire logic [7:0] filt_code_i,
  output logic [23:0] sample_o,
  output logic valid_o,
  output logic [7:0] supply_raw_o,
  output logic [7:0] supply_filt_o
);
  logic [2:0] phase = 3'h0;
  always_ff @(posedge clk_i) begin
    phase <= phase + 3'h1;
  end
  // tone flips sign so the peak detector sees both polarities; idle data is the inverted value
  assign valid_o = tone_i ? phase[1:0] == 2'h3 : push_i;
  assign sample_o = tone_i ? (phase[2] ? -amp_i : amp_i) : (push_i ? value_i : ~value_i);
  assign supply_raw_o = raw_code_i;
  assign supply_filt_o = filt_code_i;
endmodule // audio_supply_source
`default_nettype wire

//--- headroom_gain_compressor_bench.sv
// self-checking bench for the headroom gain compressor
`timescale 1ns/10ps
`default_nettype none
module headroom_gain_compressor_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sel = 1'b0;
  logic [2:0] atk = 3'h0;
  logic tone = 1'b0;
  logic push = 1'b0;
  logic shut = 1'b0;
  logic [23:0] val = 24'h000000;
  logic [7:0] raw = 8'hFF;
  logic [7:0] filt = 8'hFF;
  logic [7:0] rdata, gain, offs, sraw, sfilt;
  logic [23:0] s_in, s_out, x;
  logic rvalid, s_vin, s_vout, settled;
  logic [3:0] mode;
  logic [5:0] atten;
  logic [7:0] t_vol [4] = '{8'h80, 8'h80, 8'h8C, 8'hFF};
  logic [7:0] t_gs [4] = '{8'hA0, 8'h00, 8'hF0, 8'h00};
  int t_k [4] = '{4, 2, 1, 0};
  logic [7:0] m_gs [6] = '{8'h00, 8'h00, 8'h00, 8'h0B, 8'h0B, 8'h0B};
  logic [7:0] m_mr [6] = '{8'h00, 8'h00, 8'h00, 8'h0B, 8'h00, 8'hB0};
  logic [7:0] m_raw [6] = '{8'hFF, 8'h00, 8'hFF, 8'h64, 8'h64, 8'h00};
  logic [7:0] m_flt [6] = '{8'hFF, 8'hFF, 8'h00, 8'h64, 8'h64, 8'h00};
  logic m_sel [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  logic [3:0] m_exp [6] = '{4'h1, 4'h1, 4'h8, 4'h2, 4'h4, 4'h8};
  int fails = 0;
  int compares = 0;
  int n;
  always #2 clk = ~clk;
  audio_supply_source audio_supply_source_inst (.clk_i(clk), .tone_i(tone), .amp_i(24'h7FFFFF), .push_i(push),
    .value_i(val), .raw_code_i(raw), .filt_code_i(filt), .sample_o(s_in), .valid_o(s_vin),
    .supply_raw_o(sraw), .supply_filt_o(sfilt));
  headroom_gain_compressor #(.ATTACK_STEP_CYCLES(8), .RELEASE_UNIT_CYCLES(4)) headroom_gain_compressor_inst (
    .CORE_CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WRITE_I(wr), .REG_READ_I(rd),
    .REG_RDATA_O(rdata), .REG_RDATA_VALID_O(rvalid), .SAMPLE_I(s_in), .SAMPLE_VALID_I(s_vin),
    .SUPPLY_RAW_I(sraw), .SUPPLY_FILT_I(sfilt), .SUPPLY_FILTER_SELECT_I(sel), .ATTACK_RATE_I(atk),
    .RELEASE_RATE_I(3'h0), .SHUTDOWN_I(shut), .SAMPLE_O(s_out), .SAMPLE_VALID_O(s_vout), .ANALOG_GAIN_O(gain),
    .OUTPUT_LEVEL_OFFSET_O(offs), .COMPRESSOR_MODE_O(mode), .COMPRESSOR_ATTEN_O(atten),
    .VOLUME_SETTLED_O(settled));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic bound(input int lim);
    if (n >= lim) begin
      fails++;
      results();
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rvalid, 1'b1);
    chk(rdata, e);
    @(posedge clk);
  endtask
  // expected output is x*k/2 saturated to the 24-bit range
  function automatic logic [23:0] expect_out(input logic signed [23:0] v, input int k);
    longint r;
    r = longint'(v) * k / 2;
    r = r > 64'sd8388607 ? 64'sd8388607 : (r < -64'sd8388608 ? -64'sd8388608 : r);
    return r[23:0];
  endfunction
  task automatic step_gap();
    logic [5:0] a0;
    a0 = atten;
    n = 0;
    while (atten === a0 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    bound(5000);
  endtask
  initial begin
    void'($urandom(65));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(gain, 8'h5F);
    chk(offs, 8'h74);
    chk(mode, 4'h1);
    rreg(8'h2D, 8'h00);
    rreg(8'h31, 8'h00);
    wreg(8'h40, 8'h5A);
    rreg(8'h40, 8'h00);
    for (int c = 0; c < 16; c++) begin
      wreg(8'h2E, 8'(c));
      #1;
      chk(gain, c > 11 ? 8'hCD : 8'h5F + 8'(c) * 8'h0A);
      chk(offs, (c > 11 ? 8'hCD : 8'h5F + 8'(c) * 8'h0A) + 8'h15);
      rreg(8'h2E, 8'(c));
    end
    for (int i = 0; i < 4; i++) begin
      wreg(8'h2D, t_vol[i]);
      wreg(8'h2E, t_gs[i]);
      chk(settled, 1'b1);
      for (int j = 0; j < 12; j++) begin
        x = j == 0 ? 24'h7FFFFE : (j == 1 ? 24'h800000 : 24'($urandom) & 24'hFFFFFE);
        val <= x;
        push <= 1'b1;
        @(posedge clk);
        push <= 1'b0;
        #1;
        chk(s_vout, 1'b1);
        chk(s_out, expect_out(x, t_k[i]));
        @(posedge clk);
      end
    end
    wreg(8'h2D, 8'h80);
    wreg(8'h2D, 8'h04);
    chk(settled, 1'b0);
    n = 0;
    while (settled !== 1'b1 && n < 12000) begin
      @(posedge clk);
      n++;
    end
    bound(12000);
    chk(n > 7400 && n < 10100, 1'b1);
    wreg(8'h2D, 8'h80);
    shut <= 1'b1;
    repeat (3) @(posedge clk);
    val <= 24'h123456;
    push <= 1'b1;
    @(posedge clk);
    push <= 1'b0;
    #1;
    chk(s_out, 24'h000000);
    shut <= 1'b0;
    tone <= 1'b1;
    // slow attack so the second step after the compressor engages can be timed whole
    atk <= 3'h4 + 3'($urandom % 2);
    for (int r = 0; r < 6; r++) begin
      wreg(8'h2E, m_gs[r]);
      wreg(8'h31, m_mr[r]);
      raw <= m_raw[r];
      filt <= m_flt[r];
      sel <= m_sel[r];
      repeat (140) @(posedge clk);
      n = 0;
      while (mode !== m_exp[r] && n < 600) begin
        @(posedge clk);
        #1;
        n++;
      end
      bound(600);
      chk(mode, m_exp[r]);
      if (r == 3) begin
        x = 24'(atten);
        step_gap();
        chk(atten, x + 24'h000001);
        step_gap();
        chk(n, 8 << atk);
      end
      @(posedge clk);
    end
    results();
  end
endmodule // headroom_gain_compressor_bench
`default_nettype wire
